// ### common/ast_pkg.sv
package ast_pkg;
  // register offsets on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h1;
  localparam logic [3:0] ADDR_DIV = 4'h2;
  localparam logic [3:0] ADDR_FLAG = 4'h3;
  localparam logic [3:0] ADDR_IEN = 4'h4;
  localparam logic [3:0] ADDR_PORT = 4'h5;
  // control field positions
  localparam int CTRL_NINTH_BIT = 0;
  localparam int CTRL_EMPTY_BIT = 1;
  localparam int CTRL_HIGH_SPEED_BIT = 2;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_NINE_BIT = 6;
  localparam int FLAG_TX_BIT = 4;
  localparam int IEN_TX_BIT = 4;
  localparam int PORT_SERIAL_PORT_ENABLE_BIT = 0;
  localparam int PORT_SLEEP_BIT = 1;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam logic [7:0] DIV_RESET = 8'h00;
  // oversampling terminal counts (ratio minus one) and frame shift counts
  localparam logic [5:0] OVS_HIGH = 6'h0F;
  localparam logic [5:0] OVS_LOW = 6'h3F;
  localparam logic [3:0] FRAME_BITS_8 = 4'h9;
  localparam logic [3:0] FRAME_BITS_9 = 4'hA;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ast_bus_req_t;

  typedef struct packed {
    logic nine;
    logic high_speed;
    logic sync;
    logic enable;
    logic ninth;
  } ast_cfg_t;
endpackage

// ### src/ast_baud_gen.sv
`timescale 1ns/100ps
module ast_baud_gen
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic high_speed,
  input wire logic [7:0] divisor,
  // enable pulses
  output logic tick,
  output logic shift_tick
);
  logic [7:0] div_reg;
  logic [5:0] ovs_reg;

  // 8-bit divider then x16 / x64 oversample prescaler
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg <= 8'h00;
      ovs_reg <= 6'h00;
      tick <= 1'b0;
      shift_tick <= 1'b0;
    end
    else if (!run)
    begin
      div_reg <= 8'h00;
      ovs_reg <= 6'h00;
      tick <= 1'b0;
      shift_tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      shift_tick <= 1'b0;
      if (div_reg >= divisor)
      begin
        div_reg <= 8'h00;
        tick <= 1'b1;
        if (ovs_reg >= (high_speed ? OVS_HIGH : OVS_LOW))
        begin
          ovs_reg <= 6'h00;
          shift_tick <= 1'b1;
        end
        else
        begin
          ovs_reg <= ovs_reg + 6'h01;
        end
      end
      else
      begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end
endmodule

// ### src/ast_shifter.sv
`timescale 1ns/100ps
module ast_shifter
  import ast_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic abort,
  input wire logic shift_tick,
  input wire logic load,
  input wire logic [8:0] load_data,
  input wire logic load_nine,
  // status and line
  output logic busy,
  output logic line
);
  logic [9:0] shift_reg;
  logic [3:0] left_reg;

  // frame: start low, data lsb first, stop high
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= 10'h3FF;
      left_reg <= 4'h0;
      busy <= 1'b0;
      line <= 1'b1;
    end
    else if (abort)
    begin
      shift_reg <= 10'h3FF;
      left_reg <= 4'h0;
      busy <= 1'b0;
      line <= 1'b1;
    end
    else if (load)
    begin
      shift_reg <= load_nine ? {load_data, 1'b0} : {1'b1, load_data[7:0], 1'b0};
      left_reg <= load_nine ? FRAME_BITS_9 : FRAME_BITS_8;
      busy <= 1'b1;
    end
    else if (busy && shift_tick)
    begin
      if (left_reg == 4'h0)
      begin
        busy <= 1'b0;
        line <= 1'b1;
      end
      else
      begin
        line <= shift_reg[0];
        shift_reg <= {1'b1, shift_reg[9:1]};
        left_reg <= left_reg - 4'h1;
      end
    end
  end
endmodule

// ### src/ast_top.sv
`timescale 1ns/100ps
// Summary of operation
// R1: start, 8 or 9 data, one stop
// R2: data bits leave lsb first
// R3: dedicated 8-bit divider times bits
// R4: x16 or x64 oversample by high speed
// R5: transmitter independent, shared format and rate
// R6: no hardware parity; ninth bit software
// R7: transmitter halts during sleep; register port, flag and irq keep running
// R8: asynchronous when clocked-mode bit clear
// R9: shifter loads only after stop bit
// R10: buffer move sets empty flag
// R11: irq enable only gates request
// R12: software cannot clear empty flag
// R13: read-only shifter empty status bit
// R14: enabling transmit sets empty flag
// R15: shifting needs data and shift clock
// R16: data before enable still starts
// R17: empty shifter takes word straight through
// R18: disable aborts, resets, releases pin
// R19: nine-bit select and ninth bit value
// R20: software writes ninth bit before data
// R21: software follows documented setup order
// R22: shift register not software addressable
// R23: enabled idle line held high
module ast_top
  import ast_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire ast_pkg::ast_bus_req_t bus_req,
  output logic [7:0] rdata,
  // transmit pin
  output logic tx_out,
  output logic tx_oe,
  // interrupt request
  output logic tx_irq
);
  import ast_pkg::*;

  logic [7:0] ctrl_reg;
  logic [7:0] divisor_reg;
  logic [DATA_W-1:0] holding_reg;
  logic holding_full_reg;
  logic holding_ninth_reg;
  logic flag_reg;
  logic irq_en_reg;
  logic serial_port_enable_reg;
  logic sleep_reg;
  logic enable_prev_reg;
  logic tick;
  logic shift_tick;
  logic busy;
  logic line;
  logic run;
  logic load;
  logic abort;
  logic wr_data;
  logic [7:0] rd_mux;
  ast_cfg_t cfg;

  function automatic logic hit(input ast_bus_req_t r, input logic [3:0] a);
    hit = r.addr == a;
  endfunction

  // R19 nine-bit select and ninth bit value
  assign cfg = '{
    nine: ctrl_reg[CTRL_NINE_BIT],
    high_speed: ctrl_reg[CTRL_HIGH_SPEED_BIT],
    sync: ctrl_reg[CTRL_SYNC_BIT],
    enable: ctrl_reg[CTRL_ENABLE_BIT],
    ninth: ctrl_reg[CTRL_NINTH_BIT]
  };

  // R7 halt in sleep
  // R8 async only when clocked-mode clear
  assign run = cfg.enable && serial_port_enable_reg && !cfg.sync && !sleep_reg;
  // R18 abort on disable
  assign abort = !run;
  assign wr_data = bus_req.wr && hit(bus_req, ADDR_DATA);
  // R9 load after stop bit only
  // R16 load also when enable comes later
  assign load = run && holding_full_reg && !busy;

  // R3 dedicated 8-bit generator
  // R4 rate select
  ast_baud_gen u_baud
  (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .high_speed(cfg.high_speed),
    .divisor(divisor_reg),
    .tick(tick),
    .shift_tick(shift_tick)
  );

  // R1 frame format
  // R2 lsb first
  // R22 shifter only reachable inside
  ast_shifter u_shift
  (
    .clk(clk),
    .reset_n(reset_n),
    .abort(abort),
    .shift_tick(shift_tick),
    .load(load),
    .load_data({holding_ninth_reg, holding_reg}),
    .load_nine(cfg.nine),
    .busy(busy),
    .line(line)
  );

  // control register; bit 1 is status and not stored
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (bus_req.wr && hit(bus_req, ADDR_CTRL))
    begin
      ctrl_reg <= bus_req.wdata & 8'h75;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divisor_reg <= DIV_RESET;
      irq_en_reg <= 1'b0;
      serial_port_enable_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end
    else if (bus_req.wr)
    begin
      if (hit(bus_req, ADDR_DIV))
      begin
        divisor_reg <= bus_req.wdata;
      end
      if (hit(bus_req, ADDR_IEN))
      begin
        irq_en_reg <= bus_req.wdata[IEN_TX_BIT];
      end
      if (hit(bus_req, ADDR_PORT))
      begin
        serial_port_enable_reg <= bus_req.wdata[PORT_SERIAL_PORT_ENABLE_BIT];
        sleep_reg <= bus_req.wdata[PORT_SLEEP_BIT];
      end
    end
  end

  // holding buffer; ninth bit captured with data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      holding_reg <= '0;
      holding_ninth_reg <= 1'b0;
      holding_full_reg <= 1'b0;
    end
    else if (wr_data)
    begin
      holding_reg <= bus_req.wdata[DATA_W-1:0];
      // R20 ninth bit must already be written
      holding_ninth_reg <= cfg.ninth;
      holding_full_reg <= 1'b1;
    end
    else if (load)
    begin
      // R17 straight through when shifter idle
      holding_full_reg <= 1'b0;
    end
  end

  // empty flag; a data write in the transfer cycle leaves it clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_reg <= 1'b0;
      enable_prev_reg <= 1'b0;
    end
    else
    begin
      enable_prev_reg <= cfg.enable;
      // R12 only a data write clears
      if (wr_data)
      begin
        flag_reg <= 1'b0;
      end
      // R10 transfer sets flag
      // R14 enable rising sets flag
      else if (load || (cfg.enable && !enable_prev_reg))
      begin
        flag_reg <= 1'b1;
      end
    end
  end

  // R6 no parity logic: ninth bit passes as written
  // R5 receiver absent; shared settings live here
  always_comb
  begin
    rd_mux = 8'h00;
    case (bus_req.addr)
      ADDR_CTRL:
      begin
        rd_mux = ctrl_reg;
        // R13 shifter empty status
        rd_mux[CTRL_EMPTY_BIT] = !busy;
      end
      ADDR_DIV: rd_mux = divisor_reg;
      ADDR_FLAG: rd_mux[FLAG_TX_BIT] = flag_reg;
      ADDR_IEN: rd_mux[IEN_TX_BIT] = irq_en_reg;
      ADDR_PORT: rd_mux = {6'h00, sleep_reg, serial_port_enable_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // data register reads back the last word written
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata <= 8'h00;
    end
    else if (bus_req.rd)
    begin
      rdata <= (bus_req.addr == ADDR_DATA) ? holding_reg : rd_mux;
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

  // pin driven only while transmitter runs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
      tx_irq <= 1'b0;
    end
    else
    begin
      // R23 idle high
      tx_out <= run ? line : 1'b1;
      // R18 release pin
      tx_oe <= run;
      // R11 enable gates only the request
      tx_irq <= flag_reg && irq_en_reg;
    end
  end

  // R15 no start bit before a shift tick
  AST_NO_EARLY_START: assert property (@(posedge clk) disable iff (!reset_n)  // R15
    $fell(line) |-> $past(shift_tick))
    else $error("line left idle without shift tick");

  // R18 disable releases pin
  AST_ABORT_RELEASE: assert property (@(posedge clk) disable iff (!reset_n)  // R18
    !run |=> !tx_oe && tx_out)
    else $error("pin not released on disable");

  // R10 transfer sets flag
  AST_LOAD_SETS_FLAG: assert property (@(posedge clk) disable iff (!reset_n)  // R10
    load && !wr_data |=> flag_reg && !holding_full_reg)
    else $error("transfer did not set empty flag");

  // R12 data write clears flag
  AST_WRITE_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)  // R12
    wr_data |=> !flag_reg && holding_full_reg)
    else $error("data write did not clear flag");

  // R12 flag otherwise holds
  AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)  // R12
    flag_reg && !wr_data |=> flag_reg)
    else $error("flag cleared without data write");

  // R14 enable sets flag
  AST_ENABLE_FLAG: assert property (@(posedge clk) disable iff (!reset_n)  // R14
    $rose(cfg.enable) && !wr_data |=> flag_reg)
    else $error("enable did not set flag");

  // R9 shifter starts by load
  AST_NO_LOAD_BUSY: assert property (@(posedge clk) disable iff (!reset_n)  // R9
    busy && !$past(busy) |-> $past(load))
    else $error("shifter started without load");

  // R11 enable gates request
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!reset_n)  // R11
    tx_irq |-> $past(flag_reg) && $past(irq_en_reg))
    else $error("irq without flag and enable");

  // R13 empty status read
  AST_EMPTY_STATUS: assert property (@(posedge clk) disable iff (!reset_n)  // R13
    bus_req.rd && bus_req.addr == ADDR_CTRL |=> rdata[CTRL_EMPTY_BIT] == !$past(busy))
    else $error("empty status wrong");

  // R8 clocked mode halts pin
  AST_SYNC_HALT: assert property (@(posedge clk) disable iff (!reset_n)  // R8
    cfg.sync |=> !tx_oe)
    else $error("pin driven in clocked mode");

  // R3 shift clock from divider
  AST_SHIFT_ON_TICK: assert property (@(posedge clk) disable iff (!reset_n)  // R3
    shift_tick |-> tick)
    else $error("shift tick without divider tick");

  // R17 idle shifter takes word
  AST_PASS_THROUGH: assert property (@(posedge clk) disable iff (!reset_n)  // R17
    load |=> busy)
    else $error("load did not start shifter");

  // R23 idle line high
  AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!reset_n)  // R23
    run && !busy |=> tx_out)
    else $error("idle line not high");

  // R23 enabled pin driven
  AST_PIN_DRIVEN: assert property (@(posedge clk) disable iff (!reset_n)  // R23
    run |=> tx_oe)
    else $error("pin not driven while enabled");

  // R19 ninth bit captured
  AST_NINE_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)  // R19
    wr_data |=> holding_ninth_reg == $past(cfg.ninth))
    else $error("ninth bit not captured with data");

  // R7 sleep halts pin
  AST_SLEEP_HALT: assert property (@(posedge clk) disable iff (!reset_n)  // R7
    sleep_reg |=> !tx_oe)
    else $error("pin driven during sleep");

  // R18 abort empties shifter
  AST_ABORT_EMPTY: assert property (@(posedge clk) disable iff (!reset_n)  // R18
    !run |=> !busy)
    else $error("shifter busy after disable");

  // R1 line high after frame
  AST_STOP_HIGH: assert property (@(posedge clk) disable iff (!reset_n)  // R1
    $fell(busy) |-> line)
    else $error("line low after frame end");

  // R10 flag readable on bus
  AST_FLAG_READ: assert property (@(posedge clk) disable iff (!reset_n)  // R10
    bus_req.rd && bus_req.addr == ADDR_FLAG |=> rdata[FLAG_TX_BIT] == $past(flag_reg))
    else $error("empty flag read wrong");
endmodule

// ### verif/ast_rx_model.sv
`timescale 1ns/100ps
module ast_rx_model
(
  // clock and line
  input wire logic clk,
  input wire logic line,
  // frame setup
  input wire integer bit_clks,
  input wire logic nine,
  // decoded result
  output logic [8:0] word,
  output int count,
  output logic stop_ok
);
  // samples at mid-bit, so a wrong bit period shows as corrupt data
  initial
  begin
    count = 0;
    word = '0;
    stop_ok = 1'b1;
    forever
    begin
      @(posedge clk);
      if (line === 1'b0)
      begin
        word = '0;
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++)
        begin
          repeat (bit_clks) @(posedge clk);
          word[i] = line;
        end
        repeat (bit_clks) @(posedge clk);
        stop_ok = (line === 1'b1);
        count++;
      end
    end
  end
endmodule

// ### verif/ast_top_tb.sv
`timescale 1ns/100ps
module ast_top_tb;
  import ast_pkg::*;
  logic clk;
  logic reset_n;
  ast_bus_req_t bus_req;
  logic [7:0] rdata;
  logic tx_out;
  logic tx_oe;
  logic tx_irq;
  logic pin;
  int bit_clks;
  logic nine;
  logic [8:0] word;
  int count;
  logic stop_ok;
  int n_mismatch;
  int n_compared;
  int base;
  logic [3:0] t_addr [2];
  logic [7:0] t_off [2];
  logic [7:0] t_on [2];

  ast_top dut_u (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
    .tx_out(tx_out), .tx_oe(tx_oe), .tx_irq(tx_irq));
  // released pin floats up through the pull-up
  assign pin = tx_oe ? tx_out : 1'b1;
  ast_rx_model rx_u (.clk(clk), .line(pin), .bit_clks(bit_clks), .nine(nine),
    .word(word), .count(count), .stop_ok(stop_ok));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk(name, {1'b0, rdata}, {1'b0, e});
  endtask

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (count < n && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    chk("frames", 9'(count), 9'(n));
  endtask

  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    bus_req = '0;
    reset_n = 1'b0;
    bit_clks = 16;
    nine = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    t_addr = '{ADDR_PORT, ADDR_CTRL};
    t_off = '{8'h03, 8'h34};
    t_on = '{8'h01, 8'h24};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
    rd(ADDR_DIV, DIV_RESET, "divisor reset");
    chk("oe reset", {8'h00, tx_oe}, 9'h000);
    rd(4'hF, 8'h00, "unmapped");
    // setup order: divisor, port, irq, then enable
    wr(ADDR_DIV, 8'h00);
    wr(ADDR_PORT, 8'h01);
    wr(ADDR_IEN, 8'h10);
    wr(ADDR_CTRL, 8'h24);
    rd(ADDR_FLAG, 8'h10, "flag on enable");
    chk("irq on", {8'h00, tx_irq}, 9'h001);
    chk("idle line", {7'h00, tx_oe, tx_out}, 9'h003);
    wr(ADDR_FLAG, 8'h00);
    rd(ADDR_FLAG, 8'h10, "flag write");
    wr(ADDR_IEN, 8'h00);
    rd(ADDR_FLAG, 8'h10, "flag unmasked");
    chk("irq off", {8'h00, tx_irq}, 9'h000);
    base = count;
    wr(ADDR_DATA, 8'hA5);
    rd(ADDR_FLAG, 8'h10, "pass through");
    rd(ADDR_CTRL, 8'h24, "shifter busy");
    wr(ADDR_DATA, 8'h3C);
    rd(ADDR_FLAG, 8'h00, "held word");
    wait_rx(base + 1);
    chk("word 1", word, 9'h0A5);
    wait_rx(base + 2);
    chk("word 2", word, 9'h03C);
    chk("stop", {8'h00, stop_ok}, 9'h001);
    repeat (40) @(posedge clk);
    rd(ADDR_CTRL, 8'h26, "shifter empty");
    // ninth bit written before data, slow oversampling
    bit_clks = 64;
    nine = 1'b1;
    wr(ADDR_CTRL, 8'h61);
    wr(ADDR_DATA, 8'h5A);
    wait_rx(base + 3);
    chk("nine bit word", word, 9'h15A);
    repeat (80) @(posedge clk);
    nine = 1'b0;
    bit_clks = 48;
    wr(ADDR_DIV, 8'h02);
    wr(ADDR_CTRL, 8'h24);
    // sleep, then clocked mode: both hold the word until released
    for (int i = 0; i < 2; i++)
    begin
      base = count;
      wr(t_addr[i], t_off[i]);
      wr(ADDR_DATA, 8'hC3 ^ 8'(i));
      repeat (200) @(posedge clk);
      chk("halted", {tx_oe, 8'(count - base)}, 9'h000);
      wr(t_addr[i], t_on[i]);
      wait_rx(base + 1);
      chk("resumed word", word, {1'b0, 8'hC3 ^ 8'(i)});
    end
    repeat (100) @(posedge clk);
    wr(ADDR_DATA, 8'hF0);
    repeat (60) @(posedge clk);
    wr(ADDR_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk("abort oe", {8'h00, tx_oe}, 9'h000);
    rd(ADDR_CTRL, 8'h06, "abort reset");
    repeat (600) @(posedge clk);
    base = count;
    wr(ADDR_DATA, 8'h81);
    wr(ADDR_CTRL, 8'h24);
    wait_rx(base + 1);
    chk("data first", word, 9'h081);
    conclude();
  end
endmodule
